// ### logic/irq_book_pkg.sv
// irq_book_pkg: register map, field layout and carrier types for the
// interrupt bookkeeping block.
// assumes: one system clock, word-only AHB-Lite register access.
package irq_book_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NSRC   = 20;           // interrupt source lines
    localparam int FLT_W  = 4;            // fault status width
    localparam int EVT_W  = 2;            // event status width

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] PEND_CLR_ADDR = 32'he000e280;
    localparam logic [31:0] ACTIVE_ADDR   = 32'he000e300;
    localparam logic [31:0] MISSED_ADDR   = 32'h4000a820;
    localparam logic [31:0] FAULT_ADDR    = 32'he000ed3c;
    localparam logic [31:0] EVT_STAT_ADDR = 32'h4000a824;
    localparam logic [31:0] EVT_MASK_ADDR = 32'h4000a828;

    // ------------------------------------------------------------------
    // source bit positions
    // ------------------------------------------------------------------
    localparam int timer_one_bit         = 0;
    localparam int timer_two_bit         = 1;
    localparam int management_source_bit = 2;
    localparam int baseband_source_bit   = 3;
    localparam int sleep_timer_bit       = 4;
    localparam int serial_ctrl_one_bit   = 5;
    localparam int serial_ctrl_two_bit   = 6;
    localparam int security_source_bit   = 7;
    localparam int mac_timer_bit         = 8;
    localparam int mac_transmit_bit      = 9;
    localparam int mac_receive_bit       = 10;
    localparam int converter_bit         = 11;
    localparam int ext_line_a_bit        = 12;
    localparam int ext_line_b_bit        = 13;
    localparam int ext_line_c_bit        = 14;
    localparam int ext_line_d_bit        = 15;
    localparam int debug_source_bit      = 16;
    localparam int serial_ctrl_three_bit = 17;
    localparam int serial_ctrl_four_bit  = 18;
    localparam int usb_source_bit        = 19;

    // ------------------------------------------------------------------
    // field masks and reset values
    // ------------------------------------------------------------------
    localparam logic [NSRC-1:0]  SRC_MASK    = 20'hfffff;
    localparam logic [NSRC-1:0]  MISS_MASK   = 20'hefffc;
    localparam logic [NSRC-1:0]  ACT_SW_MASK = 20'he0000;
    localparam logic [NSRC-1:0]  SRC_RST     = 20'h00000;
    localparam logic [FLT_W-1:0] FLT_RST     = 4'h0;
    localparam logic [EVT_W-1:0] EVT_RST     = 2'h0;
    localparam logic [31:0]      WORD_ZERO   = 32'h00000000;

    // fault status bits
    localparam int FLT_OVERRUN = 0;
    localparam int FLT_UNMAP   = 1;
    localparam int FLT_PROT    = 2;
    localparam int FLT_SIZE    = 3;

    // event status bits
    localparam int EVT_MISSED  = 0;
    localparam int EVT_FAULT   = 1;

    // ------------------------------------------------------------------
    // bus codes and types
    // ------------------------------------------------------------------
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } bus_state_t;

    // one bus-fault report from the fabric
    typedef struct packed {
        logic valid;
        logic bad_width;       // byte or halfword peripheral access
        logic unaligned_word;  // word access off a 4-byte boundary
        logic unpriv_write;    // user-mode write to protected target
        logic unmapped;        // above last register or memory top
    } fault_evt_t;

    // latched address phase
    typedef struct packed {
        logic [31:0] addr;
        logic        write;
    } ahb_req_t;

endpackage : irq_book_pkg

// ### logic/irq_book.sv
// irq_book: pending, active, missed and bus-fault bookkeeping for the
// twenty peripheral interrupt lines, behind an AHB-Lite slave.
// assumes: irq_src is asynchronous; service and fault reports come
// from logic on the same clock.
//
// How it works
// - writing one clears that source's pending state
// - writing zero leaves pending state alone
// - sources timer one bit 0 to debug 16
// - serial three bit 17, serial four 18
// - active register shows interrupts being serviced
// - active bits 16:0 read-only, 19:17 writable
// - active uses source positions, resets zero
// - missed flags set on missed interrupt, RW
// - missed flags only bits 2-15, 17-19
// - byte or halfword peripheral access sets bit3
// - unaligned word access also sets bit3
// - unprivileged protected write sets bit 2
// - access above last block register sets bit1
// - access above memory top sets bit1
// - fault while any flag set sets bit0
// - fault register resets zero, 31:4 zero
// - pending resets zero, bits 31:20 unused
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
module irq_book (
    // clock, reset, enable
    input  wire logic                         clock,
    input  wire logic                         resetn,
    input  wire logic                         clk_en,
    // ahb-lite slave
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    // peripheral lines and core service reports
    input  wire logic [irq_book_pkg::NSRC-1:0] irq_src,
    input  wire logic [irq_book_pkg::NSRC-1:0] svc_start,
    input  wire logic [irq_book_pkg::NSRC-1:0] svc_end,
    input  wire irq_book_pkg::fault_evt_t      fault_evt,
    // to core
    output logic [irq_book_pkg::NSRC-1:0]     pending_out,
    output logic                              irq_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [irq_book_pkg::NSRC-1:0]  meta_reg;     // sync stage one
    logic [irq_book_pkg::NSRC-1:0]  sync_reg;     // sync stage two
    logic [irq_book_pkg::NSRC-1:0]  prev_reg;     // edge history
    logic [irq_book_pkg::NSRC-1:0]  pend_reg;     // pending per source
    logic [irq_book_pkg::NSRC-1:0]  active_reg;   // being serviced
    logic [irq_book_pkg::NSRC-1:0]  missed_reg;   // missed flags
    logic [irq_book_pkg::FLT_W-1:0] fault_reg;    // fault status
    logic [irq_book_pkg::EVT_W-1:0] evt_reg;      // event status
    logic [irq_book_pkg::EVT_W-1:0] mask_reg;     // event mask
    irq_book_pkg::bus_state_t       bus_reg;      // bus phase
    irq_book_pkg::ahb_req_t         req_reg;      // latched request
    logic                           rdy_reg;      // hreadyout
    logic                           resp_reg;     // hresp
    logic [31:0]                    rdata_reg;    // hrdata
    logic                           irq_reg;      // irq_out

    // ------------------------------------------------------------------
    // source synchroniser and edge detect
    // ------------------------------------------------------------------
    // only sync_reg and prev_reg are looked at; meta_reg feeds sync_reg and nothing else
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= irq_book_pkg::SRC_RST;
            sync_reg <= irq_book_pkg::SRC_RST;
            prev_reg <= irq_book_pkg::SRC_RST;
        end else if (clk_en) begin
            meta_reg <= irq_src;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    wire [irq_book_pkg::NSRC-1:0] rise = sync_reg & ~prev_reg;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // accept only a non-sequential or sequential transfer when selected
    wire take = hsel && hready && htrans[1];
    wire in_data = (bus_reg == irq_book_pkg::BUS_DATA);
    wire wr_go = in_data && req_reg.write;
    wire wr_pend = wr_go && (req_reg.addr == irq_book_pkg::PEND_CLR_ADDR);
    wire wr_act = wr_go && (req_reg.addr == irq_book_pkg::ACTIVE_ADDR);
    wire wr_miss = wr_go && (req_reg.addr == irq_book_pkg::MISSED_ADDR);
    wire wr_flt = wr_go && (req_reg.addr == irq_book_pkg::FAULT_ADDR);
    wire wr_evt = wr_go && (req_reg.addr == irq_book_pkg::EVT_STAT_ADDR);
    wire wr_mask = wr_go && (req_reg.addr == irq_book_pkg::EVT_MASK_ADDR);

    // write-one-clear vectors; a zero bit clears nothing
    wire [irq_book_pkg::NSRC-1:0] pend_clr =
        wr_pend ? hwdata[irq_book_pkg::NSRC-1:0]
                : irq_book_pkg::SRC_RST;
    wire [irq_book_pkg::NSRC-1:0] miss_clr =
        wr_miss ? hwdata[irq_book_pkg::NSRC-1:0]
                : irq_book_pkg::SRC_RST;
    wire [irq_book_pkg::FLT_W-1:0] flt_clr =
        wr_flt ? hwdata[irq_book_pkg::FLT_W-1:0]
               : irq_book_pkg::FLT_RST;
    wire [irq_book_pkg::EVT_W-1:0] evt_clr =
        wr_evt ? hwdata[irq_book_pkg::EVT_W-1:0]
               : irq_book_pkg::EVT_RST;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // a new edge wins over a clear in the same cycle
    wire [irq_book_pkg::NSRC-1:0] pend_next =
        ((pend_reg & ~(pend_clr | svc_start)) | rise)
        & irq_book_pkg::SRC_MASK;

    // re-assertion of a still-pending source is a miss
    wire [irq_book_pkg::NSRC-1:0] miss_set =
        rise & pend_reg & irq_book_pkg::MISS_MASK;
    wire [irq_book_pkg::NSRC-1:0] miss_next =
        ((missed_reg & ~miss_clr) | miss_set)
        & irq_book_pkg::MISS_MASK;

    // only the top three active bits take software writes
    wire [irq_book_pkg::NSRC-1:0] act_sw =
        wr_act ? ((active_reg & ~irq_book_pkg::ACT_SW_MASK)
                 | (hwdata[irq_book_pkg::NSRC-1:0]
                    & irq_book_pkg::ACT_SW_MASK))
               : active_reg;
    wire [irq_book_pkg::NSRC-1:0] act_next =
        (act_sw & ~svc_end) | svc_start;

    // fault classification; overrun needs a flag already standing
    wire [irq_book_pkg::FLT_W-1:0] flt_set = fault_evt.valid ?
        {fault_evt.bad_width | fault_evt.unaligned_word,
         fault_evt.unpriv_write,
         fault_evt.unmapped,
         |fault_reg}
        : irq_book_pkg::FLT_RST;
    wire [irq_book_pkg::FLT_W-1:0] flt_next =
        (fault_reg & ~flt_clr) | flt_set;

    // event status: any new miss, any fault
    wire [irq_book_pkg::EVT_W-1:0] evt_set = {fault_evt.valid, |miss_set};
    wire [irq_book_pkg::EVT_W-1:0] evt_next = (evt_reg & ~evt_clr) | evt_set;
    wire [irq_book_pkg::EVT_W-1:0] mask_next =
        wr_mask ? hwdata[irq_book_pkg::EVT_W-1:0] : mask_reg;

    // read mux on the latched address; unmapped reads zero
    wire [31:0] rd_req =
        (req_reg.addr == irq_book_pkg::PEND_CLR_ADDR) ? 32'(pend_reg) :
        (req_reg.addr == irq_book_pkg::ACTIVE_ADDR)   ? 32'(active_reg) :
        (req_reg.addr == irq_book_pkg::MISSED_ADDR)   ? 32'(missed_reg) :
        (req_reg.addr == irq_book_pkg::FAULT_ADDR)    ? 32'(fault_reg) :
        (req_reg.addr == irq_book_pkg::EVT_STAT_ADDR) ? 32'(evt_reg) :
        (req_reg.addr == irq_book_pkg::EVT_MASK_ADDR) ? 32'(mask_reg) :
        irq_book_pkg::WORD_ZERO;
    // writes load zero so stale data never looks like a read
    wire [31:0] rd_sel = req_reg.write ? irq_book_pkg::WORD_ZERO : rd_req;

    // ------------------------------------------------------------------
    // bookkeeping registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pend_reg   <= irq_book_pkg::SRC_RST;
            active_reg <= irq_book_pkg::SRC_RST;
            missed_reg <= irq_book_pkg::SRC_RST;
            fault_reg  <= irq_book_pkg::FLT_RST;
            evt_reg    <= irq_book_pkg::EVT_RST;
            mask_reg   <= irq_book_pkg::EVT_RST;
            irq_reg    <= 1'b0;
        end else if (clk_en) begin
            pend_reg   <= pend_next;
            active_reg <= act_next;
            missed_reg <= miss_next;
            fault_reg  <= flt_next;
            evt_reg    <= evt_next;
            mask_reg   <= mask_next;
            irq_reg    <= |(evt_next & mask_next);
        end
    end

    // ------------------------------------------------------------------
    // bus slave: one wait state per transfer
    // ------------------------------------------------------------------
    // the wait state lets a write land before any later read samples,
    // so a read straight after a write sees the new value
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_reg   <= irq_book_pkg::BUS_IDLE;
            req_reg   <= '0;
            rdy_reg   <= 1'b1;
            resp_reg  <= 1'b0;
            rdata_reg <= irq_book_pkg::WORD_ZERO;
        end else if (clk_en) begin
            resp_reg <= irq_book_pkg::HRESP_OKAY[0];
            unique case (bus_reg)
                irq_book_pkg::BUS_IDLE: begin
                    // address phase: latch, stall one cycle
                    if (take) begin
                        req_reg <= '{addr: haddr, write: hwrite};
                        bus_reg <= irq_book_pkg::BUS_DATA;
                        rdy_reg <= 1'b0;
                    end
                end
                irq_book_pkg::BUS_DATA: begin
                    // data phase end: write applied, read data out
                    bus_reg   <= irq_book_pkg::BUS_IDLE;
                    rdy_reg   <= 1'b1;
                    rdata_reg <= rd_sel;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hreadyout   = rdy_reg;
    assign hresp       = resp_reg;
    assign hrdata      = rdata_reg;
    assign pending_out = pend_reg;
    assign irq_out     = irq_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_pend_clear_one: assert property (
        clk_en && wr_pend && hwdata[0] && !rise[0]
        |=> !pend_reg[0])
        else $error("pending bit survived a write of one");

    a_pend_keep_zero: assert property (
        clk_en && wr_pend && pend_reg[5] && !hwdata[5] && !svc_start[5]
        |=> pend_reg[5])
        else $error("write of zero cleared a pending bit");

    a_src_map_low: assert property (
        clk_en && rise[irq_book_pkg::debug_source_bit]
        |=> pend_reg[irq_book_pkg::debug_source_bit])
        else $error("debug source edge not pended at bit 16");

    a_src_map_serial: assert property (
        clk_en && rise[irq_book_pkg::serial_ctrl_four_bit]
        |=> pend_reg[irq_book_pkg::serial_ctrl_four_bit])
        else $error("serial four edge not pended at bit 18");

    a_active_track: assert property (
        clk_en && svc_start[3] |=> active_reg[3] && !pend_reg[3] || rise[3])
        else $error("service start not shown as active");

    a_active_ro_low: assert property (
        clk_en && wr_act && svc_start == '0 && svc_end == '0
        |=> active_reg[16:0] == $past(active_reg[16:0]))
        else $error("software write changed read-only active bits");

    a_missed_hole: assert property (
        (missed_reg & ~irq_book_pkg::MISS_MASK) == '0)
        else $error("missed flag set at a bit without one");

    a_missed_set: assert property (
        clk_en && rise[7] && pend_reg[7] |=> missed_reg[7] && evt_reg[0])
        else $error("re-assert while pending not recorded");

    a_fault_size: assert property (
        clk_en && fault_evt.valid && fault_evt.unaligned_word
        |=> fault_reg[irq_book_pkg::FLT_SIZE])
        else $error("wrong-size fault not flagged");

    a_fault_overrun: assert property (
        clk_en && fault_evt.valid && fault_reg != '0
        |=> fault_reg[irq_book_pkg::FLT_OVERRUN])
        else $error("second fault did not set overrun");

    a_fault_first: assert property (
        clk_en && fault_evt.valid && fault_reg == '0
        |=> !fault_reg[irq_book_pkg::FLT_OVERRUN])
        else $error("first fault wrongly set overrun");

    a_bus_wait: assert property (
        clk_en && take && !in_data |=> !hreadyout)
        else $error("transfer not stalled one cycle");

    c_pend_then_clear: cover property (
        rise[0] ##[1:20] wr_pend && hwdata[0]);
    c_missed: cover property (miss_set != '0);
    c_fault_twice: cover property (
        fault_evt.valid ##[1:20] fault_evt.valid);
    c_irq: cover property ($rose(irq_out));

endmodule : irq_book

// ### verification/core_side_model.sv
// core_side_model: stands in for the processor core and the peripherals
// assumes: the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ns
module core_side_model (
    // clock
    input  wire logic                      clock,
    // towards the block
    output logic [irq_book_pkg::NSRC-1:0]  irq_src,
    output logic [irq_book_pkg::NSRC-1:0]  svc_start,
    output logic [irq_book_pkg::NSRC-1:0]  svc_end,
    output irq_book_pkg::fault_evt_t       fault_evt
);
    // quiet lines from time zero
    initial begin
        irq_src   = irq_book_pkg::SRC_RST;
        svc_start = irq_book_pkg::SRC_RST;
        svc_end   = irq_book_pkg::SRC_RST;
        fault_evt = 5'h00;
    end

    // level held past the two-flop synchroniser, then dropped
    task automatic pulse_src(input logic [19:0] b);
        irq_src <= b;
        repeat (4) @(posedge clock);
        irq_src <= irq_book_pkg::SRC_RST;
        repeat (5) @(posedge clock);
    endtask : pulse_src

    // one-cycle service begin and end reports
    task automatic service(input logic [19:0] s, e);
        svc_start <= s;
        svc_end   <= e;
        @(posedge clock);
        svc_start <= irq_book_pkg::SRC_RST;
        svc_end   <= irq_book_pkg::SRC_RST;
        @(posedge clock);
    endtask : service

    // one bus fault report, valid for a single cycle
    task automatic inject(input logic [4:0] f);
        fault_evt <= f;
        @(posedge clock);
        fault_evt <= 5'h00;
        @(posedge clock);
    endtask : inject
endmodule : core_side_model

// ### verification/irq_book_test.sv
// irq_book_test: self-checking bench for the interrupt bookkeeping block
// assumes: single AHB-Lite slave, hready fed back from hreadyout
`timescale 1ns/1ns
module irq_book_test;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        clock  = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h00000000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic        clk_en = 1'b1;
    logic [2:0]  hsize  = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        irq_out;
    logic [19:0] irq_src, svc_start, svc_end, pending_out;
    irq_book_pkg::fault_evt_t fault_evt;
    logic [31:0] rd;
    int          fail_count = 0;
    int          n_tests    = 0;
    // register addresses, copied from the package for brevity
    logic [31:0] a_pend = irq_book_pkg::PEND_CLR_ADDR;
    logic [31:0] a_act  = irq_book_pkg::ACTIVE_ADDR;
    logic [31:0] a_miss = irq_book_pkg::MISSED_ADDR;
    logic [31:0] a_flt  = irq_book_pkg::FAULT_ADDR;
    logic [31:0] a_evt  = irq_book_pkg::EVT_STAT_ADDR;
    logic [31:0] a_msk  = irq_book_pkg::EVT_MASK_ADDR;

    always #50 clock = ~clock;

    irq_book irq_book_inst (
        .clock(clock), .resetn(resetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq_src(irq_src),
        .svc_start(svc_start), .svc_end(svc_end), .fault_evt(fault_evt),
        .pending_out(pending_out), .irq_out(irq_out));

    core_side_model core_side_model_inst (
        .clock(clock), .irq_src(irq_src), .svc_start(svc_start),
        .svc_end(svc_end), .fault_evt(fault_evt));

    // ------------------------------------------------------------------
    // compare, bus and verdict tasks
    // ------------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: word %h not %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: flag %b not %b", $time, got, exp);
        end
    endtask : chk_flag

    // wait for hready high; sampled mid-cycle so no edge race
    task automatic ready_edge(output logic [31:0] r);
        @(negedge clock);
        while (hreadyout !== 1'b1) @(negedge clock);
        r = hrdata;
        @(posedge clock);
    endtask : ready_edge

    // one single word transfer; hsel stays up, idle htrans parks
    task automatic bus(input logic w, input logic [31:0] a, d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        ready_edge(rd);
        htrans <= 2'h0;
        hwdata <= d;
        ready_edge(rd);
    endtask : bus

    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic expect_rd(input logic [31:0] a, exp);
        bus(1'b0, a, 32'h00000000);
        chk_word(rd, exp);
    endtask : expect_rd

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk_flag(hresp, 1'b0);
        expect_rd(a_pend, 32'h00000000);
        expect_rd(a_act, 32'h00000000);
        expect_rd(a_miss, 32'h00000000);
        expect_rd(a_flt, 32'h00000000);
        expect_rd(32'h4000a900, 32'h00000000);
        chk_flag(irq_out, 1'b0);
    endtask : t_reset

    task automatic t_pending;
        core_side_model_inst.pulse_src(20'hfffff);
        chk_word({12'h000, pending_out}, 32'h000fffff);
        expect_rd(a_pend, 32'h000fffff);
        wr(a_pend, 32'hfff00000);
        expect_rd(a_pend, 32'h000fffff);
        wr(a_pend, 32'h000e0001);
        expect_rd(a_pend, 32'h0001fffe);
        wr(a_pend, 32'h00010000);
        expect_rd(a_pend, 32'h0000fffe);
        wr(a_pend, 32'h000fffff);
        expect_rd(a_pend, 32'h00000000);
    endtask : t_pending

    // second rise while pending: only the documented flags may latch
    task automatic t_missed;
        core_side_model_inst.pulse_src(20'hfffff);
        core_side_model_inst.pulse_src(20'hfffff);
        expect_rd(a_miss, 32'h000efffc);
        expect_rd(a_evt, 32'h00000001);
        chk_flag(irq_out, 1'b0);
        wr(a_msk, 32'h00000003);
        expect_rd(a_msk, 32'h00000003);
        chk_flag(irq_out, 1'b1);
        wr(a_miss, 32'h000efffc);
        expect_rd(a_miss, 32'h00000000);
        wr(a_evt, 32'h00000001);
        expect_rd(a_evt, 32'h00000000);
        chk_flag(irq_out, 1'b0);
    endtask : t_missed

    task automatic t_active;
        core_side_model_inst.service(20'hfffff, 20'h00000);
        expect_rd(a_act, 32'h000fffff);
        expect_rd(a_pend, 32'h00000000);
        wr(a_act, 32'h00000000);
        expect_rd(a_act, 32'h0001ffff);
        wr(a_act, 32'h000e0000);
        expect_rd(a_act, 32'h000fffff);
        core_side_model_inst.service(20'h00000, 20'hfffff);
        expect_rd(a_act, 32'h00000000);
    endtask : t_active

    task automatic t_fault;
        logic [4:0]  ev [4] = '{5'h18, 5'h14, 5'h12, 5'h11};
        logic [31:0] fx [4] = '{32'h8, 32'h8, 32'h4, 32'h2};
        for (int i = 0; i < 4; i++) begin
            core_side_model_inst.inject(ev[i]);
            expect_rd(a_flt, fx[i]);
            wr(a_flt, 32'hffffffff);
        end
        core_side_model_inst.inject(5'h11);
        core_side_model_inst.inject(5'h11);
        expect_rd(a_flt, 32'h00000003);
        expect_rd(a_evt, 32'h00000002);
        chk_flag(irq_out, 1'b1);
        wr(a_flt, 32'hffffffff);
        expect_rd(a_flt, 32'h00000000);
        wr(a_evt, 32'h00000002);
        expect_rd(a_evt, 32'h00000000);
        chk_flag(irq_out, 1'b0);
    endtask : t_fault

    // enable low: a source edge while frozen must never pend
    task automatic t_freeze;
        clk_en <= 1'b0;
        core_side_model_inst.pulse_src(20'h00001);
        chk_word({12'h000, pending_out}, 32'h00000000);
        clk_en <= 1'b1;
        repeat (4) @(posedge clock);
        chk_word({12'h000, pending_out}, 32'h00000000);
    endtask : t_freeze

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        t_reset();
        t_pending();
        t_missed();
        t_active();
        t_fault();
        t_freeze();
        print_verdict();
    end

    // roughly fifteen times the expected length of the run
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        print_verdict();
    end
endmodule : irq_book_test
